// ---- src/ddsl_pkg.sv ----
// Shared constants and types of the dual converter serial loader.
package ddsl_pkg;

   // ----------------------------------------------------------------
   // Serial word layout
   // ----------------------------------------------------------------
   localparam int WORD_W  = 16;
   localparam int DATA_W  = 8;
   localparam int DATA_LO = 0;
   localparam int DATA_HI = 7;
   localparam int POS_LOAD_DAC_A     = 8;
   localparam int POS_LOAD_DAC_B     = 9;
   localparam int POS_SPARE_BIT_4    = 10;
   localparam int POS_SHUTDOWN_DAC_A = 11;
   localparam int POS_SHUTDOWN_DAC_B = 12;
   localparam int POS_SPARE_BIT_3    = 13;
   localparam int POS_SPARE_BIT_2    = 14;
   localparam int POS_SPARE_BIT_1    = 15;
   localparam int BIT_IDX_W          = 4;
   localparam logic [BIT_IDX_W-1:0] LAST_BIT_IDX = 4'hf;

   // ----------------------------------------------------------------
   // Link timing
   // ----------------------------------------------------------------
   localparam int SYS_PERIOD_NS   = 5;
   localparam int T_SCLK_MIN_NS   = 200;
   localparam int T_HALF_NS       = T_SCLK_MIN_NS / 2;
   localparam int T_CSS_NS        = 150;
   localparam int T_CSH_NS        = 150;
   localparam int T_CSPWH_NS      = 200;
   localparam int HALF_CYC  = (T_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CSS_CYC   = (T_CSS_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CSH_CYC   = (T_CSH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CSPWH_CYC = (T_CSPWH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CNT_W     = 6;
   localparam logic [CNT_W-1:0] HALF_LOAD  = CNT_W'(HALF_CYC - 1);
   localparam logic [CNT_W-1:0] CSS_LOAD   = CNT_W'(CSS_CYC - 1);
   localparam logic [CNT_W-1:0] CSH_LOAD   = CNT_W'(CSH_CYC - 1);
   localparam logic [CNT_W-1:0] CSPWH_LOAD = CNT_W'(CSPWH_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO   = 6'h00;

   // ----------------------------------------------------------------
   // Controller registers on APB
   // ----------------------------------------------------------------
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] ADDR_CMD    = 12'h000;
   localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;
   localparam logic [APB_AW-1:0] ADDR_COUNT  = 12'h008;
   localparam int STATUS_BUSY = 0;
   localparam int STATUS_DROP = 1;
   localparam int COUNT_W     = 16;

   typedef enum logic [2:0] {
      HST_IDLE   = 3'h0,
      HST_SETUP  = 3'h1,
      HST_CLK_HI = 3'h2,
      HST_CLK_LO = 3'h3,
      HST_HOLD   = 3'h4,
      HST_GAP    = 3'h5
   } ddsl_host_state_t;

endpackage : ddsl_pkg

// ---- src/ddsl_link_if.sv ----
// Three-wire link between the controller and the converter.
`timescale 1ns/1ps
interface ddsl_link_if;
   logic cs_n;
   logic sclk;
   logic din;

   modport host (
      output cs_n,
      output sclk,
      output din
   );
   modport dev (
      input  cs_n,
      input  sclk,
      input  din
   );
endinterface : ddsl_link_if

// ---- src/ddsl_shift.sv ----
// Input shift register of the converter, clocked by the serial clock.
`timescale 1ns/1ps
module ddsl_shift (
   // Link
   input  wire logic                       i_sclk_link,
   input  wire logic                       i_cs_n,
   input  wire logic                       i_din,
   // Word
   output logic [ddsl_pkg::WORD_W-1:0]     o_word
);

   typedef struct packed {
      logic [ddsl_pkg::WORD_W-1:0] word;
   } ddsl_shift_state_t;

   ddsl_shift_state_t st;
   ddsl_shift_state_t next_st;

   always_comb begin
      next_st = st;
      // R1: shift while selected
      if (!i_cs_n) begin
         // R2: rising edge sampling
         // R4: first bit ends at top
         next_st.word = {st.word[ddsl_pkg::WORD_W-2:0], i_din};
      end
   end

   // R11: no clear between bursts
   always_ff @(posedge i_sclk_link) begin
      st <= next_st;
   end

   assign o_word = st.word;

endmodule : ddsl_shift

// ---- src/ddsl_device.sv ----
// Converter end: serial input, command execution and both converter registers.
//
// Overview of operation
// R1: Chip select low lets bits shift in.
// R2: Data sampled on serial clock rising edge.
// R3: Command runs at chip select rising edge.
// R4: Host sends most significant bit first.
// R5: Control byte then data byte.
// R6: Each control bit acts on its own.
// R7: Load A copies data into A.
// R8: Load B copies data into B.
// R9: Shutdown A bit disables converter A.
// R10: Shutdown B bit disables converter B.
// R11: Bursts may split one word.
// R12: Registers and shutdown update together.
// R13: One command loads one value only.
// R14: Shutdown keeps register value.
// R15: Leaving shutdown restores held value.
// R16: Host limits serial clock to maximum.
// R17: Host writes once after power-up.
// R18: Last sixteen bits are acted upon.
`timescale 1ns/1ps
module ddsl_device (
   // Link
   ddsl_link_if.dev                        link,
   input  wire logic                       i_sclk_link,
   // Converter state
   output logic [ddsl_pkg::DATA_W-1:0]     o_dac_a_value,
   output logic [ddsl_pkg::DATA_W-1:0]     o_dac_b_value,
   output logic                            o_shutdown_dac_a,
   output logic                            o_shutdown_dac_b,
   output logic [ddsl_pkg::DATA_W-1:0]     o_analog_out_a,
   output logic [ddsl_pkg::DATA_W-1:0]     o_analog_out_b
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ddsl_pkg::DATA_W-1:0] dac_a;
      logic [ddsl_pkg::DATA_W-1:0] dac_b;
      logic                        sd_a;
      logic                        sd_b;
      logic [ddsl_pkg::DATA_W-1:0] out_a;
      logic [ddsl_pkg::DATA_W-1:0] out_b;
   } ddsl_dev_state_t;

   ddsl_dev_state_t             st;
   ddsl_dev_state_t             next_st;
   logic [ddsl_pkg::WORD_W-1:0] word;
   logic [ddsl_pkg::DATA_W-1:0] data;

   ddsl_shift u_shift (
      .i_sclk_link (i_sclk_link),
      .i_cs_n      (link.cs_n),
      .i_din       (link.din),
      .o_word      (word)
   );

   // ----------------------------------------------------------------
   // Command execution
   // ----------------------------------------------------------------
   // R5: data byte is the low byte
   assign data = word[ddsl_pkg::DATA_HI:ddsl_pkg::DATA_LO];

   always_comb begin
      next_st = st;
      // R6: independent control bits
      // R7: load converter A
      if (word[ddsl_pkg::POS_LOAD_DAC_A]) begin
         next_st.dac_a = data;
      end
      // R8: load converter B
      // R13: same value for both
      if (word[ddsl_pkg::POS_LOAD_DAC_B]) begin
         next_st.dac_b = data;
      end
      // R9: shutdown state A
      next_st.sd_a = word[ddsl_pkg::POS_SHUTDOWN_DAC_A];
      // R10: shutdown state B
      next_st.sd_b = word[ddsl_pkg::POS_SHUTDOWN_DAC_B];
      // R14: output off, value kept
      // R15: output restored
      next_st.out_a = next_st.sd_a ? '0 : next_st.dac_a;
      next_st.out_b = next_st.sd_b ? '0 : next_st.dac_b;
   end

   // The serial clock is idle when chip select rises, so the frame's own
   // edge clocks the command. There is no reset: contents stay unknown
   // until the host's first write.
   // R3: execute on select release
   // R12: update all together
   // R18: act on last sixteen bits
   always_ff @(posedge link.cs_n) begin
      st <= next_st;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_dac_a_value    = st.dac_a;
   assign o_dac_b_value    = st.dac_b;
   assign o_shutdown_dac_a = st.sd_a;
   assign o_shutdown_dac_b = st.sd_b;
   assign o_analog_out_a   = st.out_a;
   assign o_analog_out_b   = st.out_b;

endmodule : ddsl_device

// ---- src/ddsl_host.sv ----
// Controller end: APB registers and the three-wire word sender.
`timescale 1ns/1ps
module ddsl_host (
   // Clock and reset
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rst_n,
   // APB slave
   input  wire logic                       i_psel,
   input  wire logic                       i_penable,
   input  wire logic                       i_pwrite,
   input  wire logic [ddsl_pkg::APB_AW-1:0] i_paddr,
   input  wire logic [31:0]                i_pwdata,
   output logic [31:0]                     o_prdata,
   output logic                            o_pready,
   output logic                            o_pslverr,
   // Link
   ddsl_link_if.host                       link
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      ddsl_pkg::ddsl_host_state_t       state;
      logic [ddsl_pkg::CNT_W-1:0]       cnt;
      logic [ddsl_pkg::BIT_IDX_W-1:0]   bit_idx;
      logic [ddsl_pkg::WORD_W-1:0]      shift;
      logic [ddsl_pkg::WORD_W-1:0]      cmd;
      logic [ddsl_pkg::COUNT_W-1:0]     sent;
      logic                             drop;
      logic                             cs_n;
      logic                             sclk;
      logic                             din;
      logic                             pready;
      logic                             pslverr;
      logic [31:0]                      prdata;
   } ddsl_host_reg_t;

   ddsl_host_reg_t st;
   ddsl_host_reg_t next_st;
   logic           setup_ph;
   logic           wr_cmd;
   logic           busy;

   assign setup_ph = i_psel && !i_penable;
   assign wr_cmd   = i_psel && i_penable && st.pready && i_pwrite &&
                     (i_paddr == ddsl_pkg::ADDR_CMD);
   assign busy     = (st.state != ddsl_pkg::HST_IDLE);

   always_comb begin
      next_st = st;
      // ----------------------------------------------------------------
      // APB slave: no wait states, answer prepared in the setup cycle
      // ----------------------------------------------------------------
      next_st.pready  = setup_ph;
      next_st.pslverr = 1'b0;
      next_st.prdata  = '0;
      if (setup_ph) begin
         if (i_paddr == ddsl_pkg::ADDR_CMD) begin
            next_st.prdata = {16'h0000, st.cmd};
         end else if (i_paddr == ddsl_pkg::ADDR_STATUS) begin
            next_st.prdata[ddsl_pkg::STATUS_BUSY] = busy;
            next_st.prdata[ddsl_pkg::STATUS_DROP] = st.drop;
         end else if (i_paddr == ddsl_pkg::ADDR_COUNT) begin
            next_st.prdata = {16'h0000, st.sent};
         end else begin
            next_st.pslverr = 1'b1;
         end
      end
      // A read of status clears the drop flag; a new drop in the same
      // cycle wins over the clear.
      if (i_psel && i_penable && st.pready && !i_pwrite &&
          (i_paddr == ddsl_pkg::ADDR_STATUS)) begin
         next_st.drop = 1'b0;
      end
      if (wr_cmd && busy) begin
         next_st.drop = 1'b1;
      end
      // ----------------------------------------------------------------
      // Word sender
      // ----------------------------------------------------------------
      if (st.cnt != ddsl_pkg::CNT_ZERO) begin
         next_st.cnt = st.cnt - 6'h01;
      end
      case (st.state)
         ddsl_pkg::HST_IDLE: begin
            next_st.cs_n = 1'b1;
            next_st.sclk = 1'b0;
            // R17: software's first write sets up the converter
            if (wr_cmd) begin
               next_st.cmd     = i_pwdata[ddsl_pkg::WORD_W-1:0];
               next_st.shift   = i_pwdata[ddsl_pkg::WORD_W-1:0];
               // R4: most significant bit first
               next_st.din     = i_pwdata[ddsl_pkg::WORD_W-1];
               next_st.cs_n    = 1'b0;
               next_st.bit_idx = '0;
               next_st.cnt     = ddsl_pkg::CSS_LOAD;
               next_st.state   = ddsl_pkg::HST_SETUP;
            end
         end
         ddsl_pkg::HST_SETUP: begin
            if (st.cnt == ddsl_pkg::CNT_ZERO) begin
               next_st.sclk  = 1'b1;
               next_st.cnt   = ddsl_pkg::HALF_LOAD;
               next_st.state = ddsl_pkg::HST_CLK_HI;
            end
         end
         ddsl_pkg::HST_CLK_HI: begin
            if (st.cnt == ddsl_pkg::CNT_ZERO) begin
               // Data changes on the falling edge, half a period from both
               // rising edges, which covers setup and hold.
               next_st.sclk = 1'b0;
               // R5: sixteen bits, control then data
               if (st.bit_idx == ddsl_pkg::LAST_BIT_IDX) begin
                  next_st.cnt   = ddsl_pkg::CSH_LOAD;
                  next_st.state = ddsl_pkg::HST_HOLD;
               end else begin
                  next_st.shift   = {st.shift[ddsl_pkg::WORD_W-2:0], 1'b0};
                  next_st.din     = st.shift[ddsl_pkg::WORD_W-2];
                  next_st.bit_idx = st.bit_idx + 4'h1;
                  next_st.cnt     = ddsl_pkg::HALF_LOAD;
                  next_st.state   = ddsl_pkg::HST_CLK_LO;
               end
            end
         end
         ddsl_pkg::HST_CLK_LO: begin
            // R16: period held at the minimum
            if (st.cnt == ddsl_pkg::CNT_ZERO) begin
               next_st.sclk  = 1'b1;
               next_st.cnt   = ddsl_pkg::HALF_LOAD;
               next_st.state = ddsl_pkg::HST_CLK_HI;
            end
         end
         ddsl_pkg::HST_HOLD: begin
            // R12: release select after all sixteen bits
            if (st.cnt == ddsl_pkg::CNT_ZERO) begin
               next_st.cs_n  = 1'b1;
               next_st.sent  = st.sent + 16'h0001;
               next_st.cnt   = ddsl_pkg::CSPWH_LOAD;
               next_st.state = ddsl_pkg::HST_GAP;
            end
         end
         ddsl_pkg::HST_GAP: begin
            if (st.cnt == ddsl_pkg::CNT_ZERO) begin
               next_st.state = ddsl_pkg::HST_IDLE;
            end
         end
         default: begin
            next_st.state = ddsl_pkg::HST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st       <= '0;
         st.state <= ddsl_pkg::HST_IDLE;
         st.cs_n  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_prdata  = st.prdata;
   assign o_pready  = st.pready;
   assign o_pslverr = st.pslverr;
   assign link.cs_n = st.cs_n;
   assign link.sclk = st.sclk;
   assign link.din  = st.din;

endmodule : ddsl_host

// ---- tb/ddsl_chk.sv ----
// Timing and framing checks on the three-wire link.
`timescale 1ns/1ps
module ddsl_chk (
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   // Link
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic din
);
   typedef struct packed {
      logic       sclk_q;
      logic [6:0] run;
      logic [6:0] css;
      logic [6:0] csh;
      logic [6:0] cspw;
      logic [4:0] rises;
   } ddsl_chk_st_t;
   ddsl_chk_st_t st;
   ddsl_chk_st_t next_st;

   // Counters saturate so that a long idle span never wraps into a false short gap.
   function automatic logic [6:0] ddsl_sat(input logic [6:0] v);
      return (v == 7'h7f) ? v : v + 7'h01;
   endfunction : ddsl_sat

   always_comb begin
      next_st        = st;
      next_st.sclk_q = sclk;
      next_st.run    = (sclk != st.sclk_q) ? 7'h01 : ddsl_sat(st.run);
      next_st.css    = cs_n ? 7'h00 : ddsl_sat(st.css);
      next_st.csh    = (sclk && !st.sclk_q) ? 7'h01 : ddsl_sat(st.csh);
      next_st.cspw   = cs_n ? ddsl_sat(st.cspw) : 7'h00;
      next_st.rises  = cs_n ? 5'h00 : st.rises + {4'h0, sclk && !st.sclk_q};
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st <= '{1'b0, 7'h7f, 7'h00, 7'h7f, 7'h7f, 5'h00};
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   sclk_idle_a: assert property (cs_n |-> !sclk)
      else $error("serial clock active while deselected");
   din_setup_a: assert property ($rose(sclk) |-> $stable(din))
      else $error("data moved at clock rise");
   din_hold_a: assert property (sclk && $past(sclk) |-> $stable(din))
      else $error("data moved while clock high");
   sclk_phase_a: assert property ($changed(sclk) |-> st.run >= 7'd20)
      else $error("serial clock phase too short");
   cs_setup_a: assert property ($rose(sclk) |-> st.css >= 7'd30)
      else $error("clock rose too soon after select");
   cs_hold_a: assert property ($rose(cs_n) |-> st.csh >= 7'd30)
      else $error("select rose too soon after clock");
   cs_gap_a: assert property ($fell(cs_n) |-> st.cspw >= 7'd40)
      else $error("select high pulse too short");
   word_len_a: assert property ($rose(cs_n) |-> st.rises == 5'd16)
      else $error("frame did not carry sixteen bits");
endmodule : ddsl_chk

// ---- tb/dual_dac_serial_loader_bench.sv ----
// Self-checking bench: controller and converter joined over the link.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %0h seen %0h", nm, (e), (g)); end end
module dual_dac_serial_loader_bench;
   typedef struct packed {
      logic [15:0] w;
      logic [7:0]  a;
      logic [7:0]  b;
      logic        off_a;
      logic        off_b;
   } ddsl_row_t;
   logic        i_clk_sys = 1'b0;
   logic        i_rst_n   = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [11:0] paddr     = 12'h000;
   logic [31:0] pwdata    = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  val_a [2];
   logic [7:0]  val_b [2];
   logic [7:0]  out_a [2];
   logic [7:0]  out_b [2];
   logic        sd_a  [2];
   logic        sd_b  [2];
   logic [15:0] cap;
   int          error_cnt   = 0;
   int          check_count = 0;
   ddsl_row_t   rows [7] = '{'{16'h2380, 8'h80, 8'h80, 1'b0, 1'b0},
                             '{16'h215a, 8'h5a, 8'h80, 1'b0, 1'b0},
                             '{16'h22c3, 8'h5a, 8'hc3, 1'b0, 1'b0},
                             '{16'h28ff, 8'h5a, 8'hc3, 1'b1, 1'b0},
                             '{16'h3000, 8'h5a, 8'hc3, 1'b0, 1'b1},
                             '{16'h3b3c, 8'h3c, 8'h3c, 1'b1, 1'b1},
                             '{16'he4aa, 8'h3c, 8'h3c, 1'b0, 1'b0}};

   ddsl_link_if lnk ();
   ddsl_link_if lnk2 ();

   always #2.5 i_clk_sys = ~i_clk_sys;

   // Word as seen on the wire, shifted in at each clock rise.
   always @(posedge lnk.sclk) if (!lnk.cs_n) cap <= {cap[14:0], lnk.din};

   ddsl_host u_ddsl_host (.i_clk_sys (i_clk_sys), .i_rst_n (i_rst_n), .i_psel (psel),
      .i_penable (penable), .i_pwrite (pwrite), .i_paddr (paddr), .i_pwdata (pwdata),
      .o_prdata (prdata), .o_pready (pready), .o_pslverr (pslverr), .link (lnk));
   ddsl_device u_ddsl_device (.link (lnk), .i_sclk_link (lnk.sclk),
      .o_dac_a_value (val_a[0]), .o_dac_b_value (val_b[0]), .o_shutdown_dac_a (sd_a[0]),
      .o_shutdown_dac_b (sd_b[0]), .o_analog_out_a (out_a[0]), .o_analog_out_b (out_b[0]));
   // Second converter, driven by the bench to split and overlong words.
   ddsl_device u_ddsl_device2 (.link (lnk2), .i_sclk_link (lnk2.sclk),
      .o_dac_a_value (val_a[1]), .o_dac_b_value (val_b[1]), .o_shutdown_dac_a (sd_a[1]),
      .o_shutdown_dac_b (sd_b[1]), .o_analog_out_a (out_a[1]), .o_analog_out_b (out_b[1]));
   ddsl_chk u_ddsl_chk (.i_clk_sys (i_clk_sys), .i_rst_n (i_rst_n), .cs_n (lnk.cs_n),
      .sclk (lnk.sclk), .din (lnk.din));

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge i_clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge i_clk_sys);
      penable <= 1'b1;
      do @(posedge i_clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_idle();
      logic [31:0] rd;
      logic        er;
      do apb(1'b0, ddsl_pkg::ADDR_STATUS, 32'h0, rd, er); while (rd[0] !== 1'b0);
   endtask : wait_idle

   task automatic chk_dev(input int k, input logic [7:0] a, b, input logic off_a, off_b);
      `CHK("value_a", a, val_a[k])
      `CHK("value_b", b, val_b[k])
      `CHK("shutdown_a", off_a, sd_a[k])
      `CHK("shutdown_b", off_b, sd_b[k])
      `CHK("analog_a", off_a ? 8'h00 : a, out_a[k])
      `CHK("analog_b", off_b ? 8'h00 : b, out_b[k])
   endtask : chk_dev

   // Sends n bits, most significant first, pausing with select held low mid word.
   task automatic ser(input logic [23:0] v, input int n, input logic [7:0] old);
      lnk2.cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         lnk2.din <= v[i];
         repeat (3) @(posedge i_clk_sys);
         lnk2.sclk <= 1'b1;
         repeat (3) @(posedge i_clk_sys);
         lnk2.sclk <= 1'b0;
         if (i == 8) repeat (12) @(posedge i_clk_sys);
      end
      repeat (3) @(posedge i_clk_sys);
      `CHK("held_a", old, val_a[1])
      lnk2.din  <= ~v[0];
      lnk2.cs_n <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
   endtask : ser

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   // A word takes about 720 cycles; the whole run fits well inside this span.
   initial begin
      repeat (30000) @(posedge i_clk_sys);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      logic [31:0] rd;
      logic        er;
      // The second link is idle and deselected from time zero.
      lnk2.cs_n = 1'b1;
      lnk2.sclk = 1'b0;
      lnk2.din  = 1'b0;
      repeat (12) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b1, ddsl_pkg::ADDR_CMD, {16'hffff, rows[i].w}, rd, er);
         wait_idle();
         `CHK("wire_word", rows[i].w, cap)
         chk_dev(0, rows[i].a, rows[i].b, rows[i].off_a, rows[i].off_b);
         apb(1'b0, ddsl_pkg::ADDR_COUNT, 32'h0, rd, er);
         `CHK("count", 32'(i + 1), rd)
         $display("row %0d done", i);
      end
      apb(1'b1, ddsl_pkg::ADDR_CMD, 32'h0000_2301, rd, er);
      apb(1'b1, ddsl_pkg::ADDR_CMD, 32'h0000_2302, rd, er);
      apb(1'b0, ddsl_pkg::ADDR_STATUS, 32'h0, rd, er);
      `CHK("status_drop", 32'h3, rd)
      apb(1'b0, ddsl_pkg::ADDR_STATUS, 32'h0, rd, er);
      `CHK("status_clear", 32'h1, rd)
      wait_idle();
      chk_dev(0, 8'h01, 8'h01, 1'b0, 1'b0);
      apb(1'b0, 12'h00c, 32'h0, rd, er);
      `CHK("slverr", 1'b1, er)
      `CHK("unmapped", 32'h0, rd)
      $display("busy and unmapped test done");
      i_rst_n <= 1'b0;
      repeat (12) @(posedge i_clk_sys);
      `CHK("cs_n_idle", 1'b1, lnk.cs_n)
      `CHK("sclk_idle", 1'b0, lnk.sclk)
      i_rst_n <= 1'b1;
      apb(1'b0, ddsl_pkg::ADDR_COUNT, 32'h0, rd, er);
      `CHK("count_reset", 32'h0, rd)
      chk_dev(0, 8'h01, 8'h01, 1'b0, 1'b0);
      $display("reset test done");
      ser(24'h0023a5, 16, 8'hxx);
      chk_dev(1, 8'ha5, 8'ha5, 1'b0, 1'b0);
      ser(24'h0f2b0f, 20, 8'ha5);
      chk_dev(1, 8'h0f, 8'h0f, 1'b1, 1'b0);
      $display("split and long word test done");
      report_and_stop();
   end
endmodule : dual_dac_serial_loader_bench
